// ===== logic/mac_error_statistics_counters.sv
// Ethernet MAC error statistics: collision, late, excessive collision,
// jabber and undersize tallies with sticky event status and interrupt.
// Assumes frame events are single-cycle pulses from the MAC paths and
// that software uses the plain register port synchronous to sys_clk_i.
//
// Behaviour
// - Late-collision tally counts frames colliding after 512 bit times.
// - A late collision also advances the ordinary collision tally.
// - Excessive-collision tally counts frames abandoned after 16 collisions.
// - Jabber tally: errored frames over 1518 bytes, or 1536 with bit 8.
// - Undersize tally: error-free frames shorter than 64 bytes.
// - Transmitter abandons a frame and flags error after 16 collided attempts.
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module mac_error_statistics_counters
(
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_n_i,
   // Register port
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [31:0] reg_rdata_o,
   // Transmit path events
   input  wire logic        tx_frame_start_i,
   input  wire logic        tx_collision_i,
   input  wire logic [15:0] tx_bit_count_i,
   output logic             tx_abort_o,
   // Receive path events
   input  wire logic        rx_frame_end_i,
   input  wire logic [15:0] rx_length_i,
   input  wire logic        rx_crc_err_i,
   input  wire logic        rx_align_err_i,
   input  wire logic        rx_symbol_err_i,
   // Interrupt
   output logic             irq_o
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   // Counter increment, load and value
   logic [mac_stat_pkg::NUM_CNT-1:0] cnt_inc;
   logic [mac_stat_pkg::NUM_CNT-1:0] cnt_wr;
   logic [7:0]                       cnt_val [mac_stat_pkg::NUM_CNT];

   // Sticky status, mask and long-frame option
   logic [mac_stat_pkg::NUM_CNT-1:0] status;
   logic [mac_stat_pkg::NUM_CNT-1:0] next_status;
   logic [mac_stat_pkg::NUM_CNT-1:0] mask;
   logic [mac_stat_pkg::NUM_CNT-1:0] next_mask;
   logic                             big_frame;
   logic                             next_big_frame;

   // Registered outputs
   logic [31:0]                      next_rdata;
   logic                             next_irq;
   logic                             next_abort;

   // Receive frame checks
   logic                             rx_any_err;
   logic [15:0]                      rx_limit;
   logic                             jabber_hit;
   logic                             undersize_hit;

   // Tracker pulses
   logic                             late_pulse;
   logic                             excess_pulse;

   // ----------------------------------------------------------------
   // Transmit collision tracking
   // ----------------------------------------------------------------
   retry_if u_retry_if ();

   // Raw collision report goes straight to the tracker
   assign u_retry_if.frame_start = tx_frame_start_i;
   assign u_retry_if.collision   = tx_collision_i;
   assign u_retry_if.bit_count   = tx_bit_count_i;
   assign late_pulse             = u_retry_if.late;
   assign excess_pulse           = u_retry_if.excess;

   tx_retry_tracker u_retry
   (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .port_if   (u_retry_if.trk)
   );

   // ----------------------------------------------------------------
   // Receive frame classification
   // ----------------------------------------------------------------
   // Any of the three receive faults disqualifies or qualifies a frame
   assign rx_any_err = rx_crc_err_i || rx_align_err_i || rx_symbol_err_i;

   // Long-frame option widens the jabber threshold
   assign rx_limit = big_frame ? mac_stat_pkg::MAX_FRAME_BIG
                               : mac_stat_pkg::MAX_FRAME_STD;

   // Frame-end checks, evaluated only on the end pulse
   assign jabber_hit    = rx_frame_end_i && (rx_length_i > rx_limit) && rx_any_err;
   assign undersize_hit = rx_frame_end_i && (rx_length_i < mac_stat_pkg::MIN_FRAME)
                          && !rx_any_err;

   // ----------------------------------------------------------------
   // Counter event and load routing
   // ----------------------------------------------------------------
   // Every collision, late ones included, feeds the ordinary tally
   always_comb
   begin
      cnt_inc                           = '0;
      cnt_inc[mac_stat_pkg::IDX_COLL]   = tx_collision_i;
      cnt_inc[mac_stat_pkg::IDX_LATE]   = late_pulse;
      cnt_inc[mac_stat_pkg::IDX_EXCESS] = excess_pulse;
      cnt_inc[mac_stat_pkg::IDX_JABBER] = jabber_hit;
      cnt_inc[mac_stat_pkg::IDX_UNDER]  = undersize_hit;
   end

   // Write decode per counter slot
   always_comb
   begin
      cnt_wr = '0;
      if (reg_wr_i)
      begin
         if (reg_addr_i == mac_stat_pkg::OFS_COLL)
            cnt_wr[mac_stat_pkg::IDX_COLL] = 1'b1;
         else if (reg_addr_i == mac_stat_pkg::OFS_LATE)
            cnt_wr[mac_stat_pkg::IDX_LATE] = 1'b1;
         else if (reg_addr_i == mac_stat_pkg::OFS_EXCESS)
            cnt_wr[mac_stat_pkg::IDX_EXCESS] = 1'b1;
         else if (reg_addr_i == mac_stat_pkg::OFS_JABBER)
            cnt_wr[mac_stat_pkg::IDX_JABBER] = 1'b1;
         else if (reg_addr_i == mac_stat_pkg::OFS_UNDER)
            cnt_wr[mac_stat_pkg::IDX_UNDER] = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Counter slots
   // ----------------------------------------------------------------
   // Only the low byte is loaded; upper write bits are dropped
   generate
      for (genvar g = 0; g < mac_stat_pkg::NUM_CNT; g++)
      begin : g_cnt
         stat_if u_cnt_if ();

         assign u_cnt_if.inc   = cnt_inc[g];
         assign u_cnt_if.wr    = cnt_wr[g];
         assign u_cnt_if.wdata = reg_wdata_i[7:0];
         assign cnt_val[g]     = u_cnt_if.value;

         stat_counter u_cnt
         (
            .sys_clk_i (sys_clk_i),
            .rst_n_i   (rst_n_i),
            .port_if   (u_cnt_if.ctr)
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Control, status and mask registers
   // ----------------------------------------------------------------
   // Set wins over clear so an event in a clearing cycle is kept
   always_comb
   begin
      next_status    = status;
      next_mask      = mask;
      next_big_frame = big_frame;
      if (reg_wr_i)
      begin
         if (reg_addr_i == mac_stat_pkg::OFS_STATUS)
            next_status = status & ~reg_wdata_i[mac_stat_pkg::NUM_CNT-1:0];
         else if (reg_addr_i == mac_stat_pkg::OFS_MASK)
            next_mask = reg_wdata_i[mac_stat_pkg::NUM_CNT-1:0];
         else if (reg_addr_i == mac_stat_pkg::OFS_NETCFG)
            next_big_frame = reg_wdata_i[mac_stat_pkg::CFG_BIG_BIT];
      end
      next_status = next_status | cnt_inc;
   end

   // Interrupt level from masked sticky events
   assign next_irq = |(next_status & next_mask);

   // Abandon flag to the transmitter
   assign next_abort = excess_pulse;

   // Status, mask, option and flag registers
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         status     <= mac_stat_pkg::STATUS_RESET;
         mask       <= mac_stat_pkg::MASK_RESET;
         big_frame  <= mac_stat_pkg::BIG_RESET;
         irq_o      <= 1'b0;
         tx_abort_o <= 1'b0;
      end
      else
      begin
         status     <= next_status;
         mask       <= next_mask;
         big_frame  <= next_big_frame;
         irq_o      <= next_irq;
         tx_abort_o <= next_abort;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Read data stand one cycle only; unmapped or idle cycles read zero
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (reg_rd_i)
      begin
         if (reg_addr_i == mac_stat_pkg::OFS_COLL)
            next_rdata[7:0] = cnt_val[mac_stat_pkg::IDX_COLL];
         else if (reg_addr_i == mac_stat_pkg::OFS_LATE)
            next_rdata[7:0] = cnt_val[mac_stat_pkg::IDX_LATE];
         else if (reg_addr_i == mac_stat_pkg::OFS_EXCESS)
            next_rdata[7:0] = cnt_val[mac_stat_pkg::IDX_EXCESS];
         else if (reg_addr_i == mac_stat_pkg::OFS_JABBER)
            next_rdata[7:0] = cnt_val[mac_stat_pkg::IDX_JABBER];
         else if (reg_addr_i == mac_stat_pkg::OFS_UNDER)
            next_rdata[7:0] = cnt_val[mac_stat_pkg::IDX_UNDER];
         else if (reg_addr_i == mac_stat_pkg::OFS_NETCFG)
            next_rdata[mac_stat_pkg::CFG_BIG_BIT] = big_frame;
         else if (reg_addr_i == mac_stat_pkg::OFS_STATUS)
            next_rdata[mac_stat_pkg::NUM_CNT-1:0] = status;
         else if (reg_addr_i == mac_stat_pkg::OFS_MASK)
            next_rdata[mac_stat_pkg::NUM_CNT-1:0] = mask;
      end
   end

   // Read data register
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         reg_rdata_o <= 32'h0000_0000;
      else
         reg_rdata_o <= next_rdata;
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Late collision seen on the report, then the double count
   sequence s_late_report;
      tx_collision_i && (tx_bit_count_i >= mac_stat_pkg::SLOT_BITS);
   endsequence

   sequence s_late_counted;
      late_pulse ##1 (status[mac_stat_pkg::IDX_LATE] && status[mac_stat_pkg::IDX_COLL]);
   endsequence

   chk_late_detect: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      s_late_report |=> s_late_counted)
      else $error("late collision not tallied");

   chk_early_quiet: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      tx_collision_i && (tx_bit_count_i < mac_stat_pkg::SLOT_BITS) |=> !late_pulse)
      else $error("early collision counted as late");

   chk_dual_tally: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      late_pulse |-> $past(cnt_inc[mac_stat_pkg::IDX_COLL]))
      else $error("late collision missed the collision tally");

   chk_excess_count: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      excess_pulse && !cnt_wr[mac_stat_pkg::IDX_EXCESS]
      |=> cnt_val[mac_stat_pkg::IDX_EXCESS]
          == 8'($past(cnt_val[mac_stat_pkg::IDX_EXCESS]) + 8'h01))
      else $error("excessive collision tally did not advance");

   chk_abort_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      excess_pulse |=> tx_abort_o ##1 !tx_abort_o)
      else $error("abandon flag not one cycle");

   // Receive tallies
   chk_jabber_count: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      rx_frame_end_i && rx_any_err && !cnt_wr[mac_stat_pkg::IDX_JABBER]
      && (rx_length_i > (big_frame ? mac_stat_pkg::MAX_FRAME_BIG : mac_stat_pkg::MAX_FRAME_STD))
      |=> cnt_val[mac_stat_pkg::IDX_JABBER]
          == 8'($past(cnt_val[mac_stat_pkg::IDX_JABBER]) + 8'h01))
      else $error("jabber frame not counted");

   chk_jabber_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !jabber_hit && !cnt_wr[mac_stat_pkg::IDX_JABBER]
      |=> $stable(cnt_val[mac_stat_pkg::IDX_JABBER]))
      else $error("jabber tally moved without cause");

   chk_under_count: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      rx_frame_end_i && !rx_any_err && (rx_length_i < mac_stat_pkg::MIN_FRAME)
      && !cnt_wr[mac_stat_pkg::IDX_UNDER]
      |=> cnt_val[mac_stat_pkg::IDX_UNDER]
          == 8'($past(cnt_val[mac_stat_pkg::IDX_UNDER]) + 8'h01))
      else $error("undersize frame not counted");

   // Register port
   chk_read_back: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      reg_rd_i && (reg_addr_i == mac_stat_pkg::OFS_LATE)
      |=> reg_rdata_o == {24'h00_0000, $past(cnt_val[mac_stat_pkg::IDX_LATE])})
      else $error("late tally read back wrong");

   chk_load_value: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      cnt_wr[mac_stat_pkg::IDX_UNDER] && !cnt_inc[mac_stat_pkg::IDX_UNDER]
      |=> cnt_val[mac_stat_pkg::IDX_UNDER] == $past(reg_wdata_i[7:0]))
      else $error("undersize tally did not load");

   chk_irq_level: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      irq_o == |(status & mask))
      else $error("interrupt level disagrees with status");

endmodule // mac_error_statistics_counters

`default_nettype wire

// ===== logic/mac_stat_pkg.sv
// Constants for the MAC error statistics counters.
// Assumes a 32-bit register port with byte addresses and one system clock.
package mac_stat_pkg;

   // ----------------------------------------------------------------
   // Widths and counter slots
   // ----------------------------------------------------------------
   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 32;
   localparam int CNT_W      = 8;
   localparam int NUM_CNT    = 5;
   localparam int IDX_COLL   = 0;
   localparam int IDX_LATE   = 1;
   localparam int IDX_EXCESS = 2;
   localparam int IDX_JABBER = 3;
   localparam int IDX_UNDER  = 4;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_COLL   = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_LATE   = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_EXCESS = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_JABBER = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_UNDER  = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_NETCFG = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h1c;

   // ----------------------------------------------------------------
   // Reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [CNT_W-1:0]   CNT_RESET    = 8'h00;
   localparam logic [NUM_CNT-1:0] STATUS_RESET = 5'h00;
   localparam logic [NUM_CNT-1:0] MASK_RESET   = 5'h00;
   localparam logic               BIG_RESET    = 1'b0;
   localparam int                 CFG_BIG_BIT  = 8;

   // ----------------------------------------------------------------
   // Frame and collision limits
   // ----------------------------------------------------------------
   localparam logic [15:0] SLOT_BITS      = 16'h0200;
   localparam logic [15:0] MAX_FRAME_STD  = 16'h05ee;
   localparam logic [15:0] MAX_FRAME_BIG  = 16'h0600;
   localparam logic [15:0] MIN_FRAME      = 16'h0040;
   localparam logic [4:0]  MAX_COLLISIONS = 5'h10;

endpackage

// ===== logic/stat_links.sv
// Interfaces between the statistics top and its counter and retry modules.
// Assumes all parties run on the same system clock.
`timescale 1ns/1ns
`default_nettype none

// Counter slot: increment, software load and current value
interface stat_if;
   logic       inc;
   logic       wr;
   logic [7:0] wdata;
   logic [7:0] value;
   modport ctr   (input inc, input wr, input wdata, output value);
   modport owner (output inc, output wr, output wdata, input value);
endinterface // stat_if

// Retry tracker: collision report in, late and abandon pulses out
interface retry_if;
   logic        frame_start;
   logic        collision;
   logic [15:0] bit_count;
   logic        late;
   logic        excess;
   modport trk   (input frame_start, input collision, input bit_count,
                  output late, output excess);
   modport owner (output frame_start, output collision, output bit_count,
                  input late, input excess);
endinterface // retry_if

`default_nettype wire

// ===== logic/stat_counter.sv
// One 8-bit statistics tally with software load.
// Assumes increment and write are single-cycle pulses.
`timescale 1ns/1ns
`default_nettype none

module stat_counter
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Counter slot
   stat_if.ctr      port_if
);

   logic [7:0] next_value;

   // Load first, then count, so an event during a write is kept
   always_comb
   begin
      next_value = port_if.wr ? port_if.wdata : port_if.value;
      if (port_if.inc)
      begin
         next_value = 8'(next_value + 8'h01);
      end
   end

   // Counter register
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         port_if.value <= mac_stat_pkg::CNT_RESET;
      else
         port_if.value <= next_value;
   end

   chk_count_step: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      port_if.inc && !port_if.wr |=> port_if.value == 8'($past(port_if.value) + 8'h01))
      else $error("tally did not advance by one");

endmodule // stat_counter

`default_nettype wire

// ===== logic/tx_retry_tracker.sv
// Per-frame collision tracker: flags late collisions and retry exhaustion.
// Assumes one collision pulse per failed attempt, with bits sent so far.
`timescale 1ns/1ns
`default_nettype none

module tx_retry_tracker
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Collision report
   retry_if.trk     port_if
);

   logic [4:0] tries;
   logic [4:0] next_tries;
   logic       next_late;
   logic       next_excess;

   // Attempt count; a new frame clears it before its own collision counts
   always_comb
   begin
      next_tries  = port_if.frame_start ? 5'h00 : tries;
      next_late   = port_if.collision && (port_if.bit_count >= mac_stat_pkg::SLOT_BITS);
      next_excess = 1'b0;
      if (port_if.collision)
      begin
         if (next_tries == 5'(mac_stat_pkg::MAX_COLLISIONS - 5'h01))
         begin
            next_excess = 1'b1;
            next_tries  = 5'h00;
         end
         else
         begin
            next_tries = 5'(next_tries + 5'h01);
         end
      end
   end

   // Tracker registers
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         tries          <= 5'h00;
         port_if.late   <= 1'b0;
         port_if.excess <= 1'b0;
      end
      else
      begin
         tries          <= next_tries;
         port_if.late   <= next_late;
         port_if.excess <= next_excess;
      end
   end

   chk_excess_at_limit: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      port_if.excess |-> $past(port_if.collision) && $past(tries) == 5'h0f)
      else $error("abandon not on sixteenth collision");

endmodule // tx_retry_tracker

`default_nettype wire

// ===== testbench/phy_event_model.sv
// Behavioural stand-in for the MAC paths facing the PHY: event pulses.
// Assumes the bench calls one task at a time, from one process.
`timescale 1ns/1ns
`default_nettype none

module phy_event_model
(
   // Clock
   input  wire logic        sys_clk_i,
   // Transmit events
   output logic             tx_frame_start_o,
   output logic             tx_collision_o,
   output logic [15:0]      tx_bit_count_o,
   // Receive events
   output logic             rx_frame_end_o,
   output logic [15:0]      rx_length_o,
   output logic [2:0]       rx_err_o
);
   // ----------------------------------------------------------------
   // Idle levels at time zero
   // ----------------------------------------------------------------
   initial
   begin
      tx_frame_start_o = 1'b0;
      tx_collision_o   = 1'b0;
      tx_bit_count_o   = 16'h0000;
      rx_frame_end_o   = 1'b0;
      rx_length_o      = 16'h0000;
      rx_err_o         = 3'h0;
   end

   // ----------------------------------------------------------------
   // Event tasks
   // ----------------------------------------------------------------
   // One failed attempt; qualifiers invert once the pulse is over so a
   // design that samples late sees wrong values, not stale good ones
   task automatic collide(input logic [15:0] bits, input logic start);
      @(posedge sys_clk_i);
      tx_frame_start_o <= start;
      tx_collision_o   <= 1'b1;
      tx_bit_count_o   <= bits;
      @(posedge sys_clk_i);
      tx_frame_start_o <= 1'b0;
      tx_collision_o   <= 1'b0;
      tx_bit_count_o   <= ~bits;
   endtask

   // End of one received frame with its length and error levels
   task automatic rx_frame(input logic [15:0] len, input logic [2:0] err);
      @(posedge sys_clk_i);
      rx_frame_end_o <= 1'b1;
      rx_length_o    <= len;
      rx_err_o       <= err;
      @(posedge sys_clk_i);
      rx_frame_end_o <= 1'b0;
      rx_length_o    <= ~len;
      rx_err_o       <= ~err;
   endtask
endmodule // phy_event_model

`default_nettype wire

// ===== testbench/mac_error_statistics_counters_bench.sv
// Self-checking bench for the MAC error statistics counters.
// Assumes the design package and the event model are compiled first.
`timescale 1ns/1ns
`default_nettype none

module mac_error_statistics_counters_bench;
   logic        sys_clk_i;
   logic        rst_n_i;
   logic [7:0]  reg_addr_i;
   logic [31:0] reg_wdata_i;
   logic        reg_wr_i;
   logic        reg_rd_i;
   logic [31:0] reg_rdata_o;
   logic        tx_frame_start_i, tx_collision_i, tx_abort_o, irq_o;
   logic [15:0] tx_bit_count_i, rx_length_i;
   logic        rx_frame_end_i;
   logic [2:0]  rx_err;
   int          checks, miscompares;
   int          aborts = 0;

   mac_error_statistics_counters DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .tx_frame_start_i(tx_frame_start_i), .tx_collision_i(tx_collision_i),
      .tx_bit_count_i(tx_bit_count_i), .tx_abort_o(tx_abort_o),
      .rx_frame_end_i(rx_frame_end_i), .rx_length_i(rx_length_i),
      .rx_crc_err_i(rx_err[0]), .rx_align_err_i(rx_err[1]),
      .rx_symbol_err_i(rx_err[2]), .irq_o(irq_o));

   phy_event_model phy (.sys_clk_i(sys_clk_i), .tx_frame_start_o(tx_frame_start_i),
      .tx_collision_o(tx_collision_i), .tx_bit_count_o(tx_bit_count_i),
      .rx_frame_end_o(rx_frame_end_i), .rx_length_o(rx_length_i), .rx_err_o(rx_err));

   // ----------------------------------------------------------------
   // Clock, abort pulse tally and shared tasks
   // ----------------------------------------------------------------
   initial
   begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end

   // Every high cycle counts, so a long pulse shows up
   always @(posedge sys_clk_i)
      if (tx_abort_o === 1'b1)
         aborts++;

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      reg_wr_i    <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      @(posedge sys_clk_i);
      reg_wr_i    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge sys_clk_i);
      reg_rd_i   <= 1'b1;
      reg_addr_i <= a;
      @(posedge sys_clk_i);
      reg_rd_i   <= 1'b0;
      #1 v = reg_rdata_o;
   endtask

   task automatic final_report;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   // Whole map reads zero after reset, unmapped 0x20 too
   task automatic t_reset;
      logic [31:0] v;
      check("irq after reset", {31'h0, irq_o}, 32'h0);
      for (int a = 0; a <= 32; a += 4)
      begin
         rd(a[7:0], v);
         check("reset value", v, 32'h0);
      end
      $display("test reset done");
   endtask

   // Counters load the low byte only; unmapped writes vanish
   task automatic t_rw;
      logic [31:0] v;
      for (int a = 0; a <= 16; a += 4)
      begin
         wr(a[7:0], 32'hffffff51 + a);
         rd(a[7:0], v);
         check("counter load", v, 32'h51 + a);
         wr(a[7:0], 32'h0);
      end
      wr(8'h24, 32'h0000_00ff);
      rd(8'h24, v);
      check("unmapped read", v, 32'h0);
      $display("test register access done");
   endtask

   // Boundary at 511 and 512 bits: only the second is late
   task automatic t_late;
      logic [31:0] v;
      phy.collide(16'h01ff, 1'b1);
      phy.collide(16'h0200, 1'b0);
      rd(mac_stat_pkg::OFS_COLL, v);
      check("collision tally", v, 32'h2);
      rd(mac_stat_pkg::OFS_LATE, v);
      check("late tally", v, 32'h1);
      $display("test late collision done");
   endtask

   // Fifteen collisions are retried, the sixteenth abandons the frame
   task automatic t_excess;
      logic [31:0] v;
      int          a0;
      a0 = aborts;
      for (int i = 0; i < 15; i++)
         phy.collide(16'h0064, i == 0);
      rd(mac_stat_pkg::OFS_EXCESS, v);
      check("excess before limit", v, 32'h0);
      check("no early abort", 32'(aborts - a0), 32'h0);
      phy.collide(16'h0064, 1'b0);
      for (int n = 0; n < 4 && aborts == a0; n++)
         @(posedge sys_clk_i);
      check("abort pulses", 32'(aborts - a0), 32'h1);
      phy.collide(16'h0064, 1'b0);
      rd(mac_stat_pkg::OFS_EXCESS, v);
      check("excess tally", v, 32'h1);
      repeat (2) @(posedge sys_clk_i);
      check("count restarts", 32'(aborts - a0), 32'h1);
      $display("test excessive collision done");
   endtask

   // Length limits on both sides of each boundary, each error kind
   task automatic t_rx;
      logic [15:0] lens [10] = '{16'h05ee, 16'h05ef, 16'h05ef, 16'h0640, 16'h0640,
                                 16'h003f, 16'h0040, 16'h003f, 16'h0600, 16'h0601};
      logic [2:0]  errs [10] = '{3'h1, 3'h1, 3'h0, 3'h2, 3'h4, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1};
      logic [31:0] v, jab, und;
      logic [15:0] lim;
      jab = 32'h0;
      und = 32'h0;
      lim = mac_stat_pkg::MAX_FRAME_STD;
      for (int i = 0; i < 10; i++)
      begin
         if (i == 8)
         begin
            wr(mac_stat_pkg::OFS_NETCFG, 32'h0000_0100);
            lim = mac_stat_pkg::MAX_FRAME_BIG;
         end
         phy.rx_frame(lens[i], errs[i]);
         jab += (lens[i] > lim && errs[i] != 3'h0);
         und += (lens[i] < mac_stat_pkg::MIN_FRAME && errs[i] == 3'h0);
         rd(mac_stat_pkg::OFS_JABBER, v);
         check("jabber tally", v, jab);
         rd(mac_stat_pkg::OFS_UNDER, v);
         check("undersize tally", v, und);
      end
      $display("test receive frames done");
   endtask

   // Sticky status raises the line only while its mask bit is set
   task automatic t_irq;
      logic [31:0] v;
      wr(mac_stat_pkg::OFS_STATUS, 32'h1f);
      wr(mac_stat_pkg::OFS_MASK, 32'h10);
      #1;
      check("irq idle", {31'h0, irq_o}, 32'h0);
      phy.rx_frame(16'h003f, 3'h0);
      repeat (3) @(posedge sys_clk_i);
      #1;
      check("irq raised", {31'h0, irq_o}, 32'h1);
      rd(mac_stat_pkg::OFS_STATUS, v);
      check("status undersize", v, 32'h10);
      wr(mac_stat_pkg::OFS_STATUS, 32'h10);
      repeat (2) @(posedge sys_clk_i);
      #1;
      check("irq cleared", {31'h0, irq_o}, 32'h0);
      wr(mac_stat_pkg::OFS_MASK, 32'h0);
      phy.rx_frame(16'h003f, 3'h0);
      repeat (3) @(posedge sys_clk_i);
      #1;
      check("irq masked", {31'h0, irq_o}, 32'h0);
      $display("test interrupt done");
   endtask

   // ----------------------------------------------------------------
   // Main sequence: reset for four cycles, then the scenarios
   // ----------------------------------------------------------------
   initial
   begin
      checks      = 0;
      miscompares = 0;
      rst_n_i     = 1'b0;
      reg_addr_i  = 8'h00;
      reg_wdata_i = 32'h0;
      reg_wr_i    = 1'b0;
      reg_rd_i    = 1'b0;
      repeat (4) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_rw();
      t_late();
      t_excess();
      t_rx();
      t_irq();
      final_report();
   end
endmodule // mac_error_statistics_counters_bench

`default_nettype wire
